//--- cpu_register_set_test.sv
module cpu_register_set_test;
    timeunit 1ns;
    timeprecision 1ns;
    import crs_pkg::*;
    logic        mclk, rst_b, awv, wv, bready, arv, rready, awrdy, wrdy, bvalid, arrdy, rvalid;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, v, xdata;
    logic [1:0]  bresp, rresp, xchk;
    logic [19:0] nip;
    logic [10:0] flags;
    crs_wr_t     exec_wr;
    crs_alu_t    exec_alu;
    crs_rd_t     exec_rd;
    logic [2:0]  pc_step;
    logic [33:0] expq[$];
    int          errors, compares;
    crs_exec i_crs_exec (.MCLK(mclk), .EXEC_WR(exec_wr), .EXEC_ALU(exec_alu),
        .EXEC_PC_STEP(pc_step), .EXEC_RD(exec_rd));
    crs_core i_crs_core (.MCLK(mclk), .RST_B(rst_b), .EXEC_WR(exec_wr), .EXEC_ALU(exec_alu),
        .EXEC_PC_STEP(pc_step), .EXEC_RD(exec_rd), .EXEC_RD_DATA(xdata), .NIP(nip), .FLAGS(flags),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) begin : watch
        logic [33:0] e, g;
        if (xchk != 2'h0 || (bvalid && bready) || (rvalid && rready)) begin
            e = expq.pop_front();
            g = (xchk == 2'h1) ? {2'h0, xdata} : (xchk == 2'h2) ? {14'h0, nip}
              : (xchk == 2'h3) ? {23'h0, flags} : rvalid ? {rresp, rdata} : {bresp, 32'h0};
            compares++;
            if (g !== e) begin
                errors++;
                $display("[ERR] %0t exp %h got %h", $time, e, g);
            end
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic pa, pw, ta, tw;
        expq.push_back({r, 32'h0});
        {pa, pw} = 2'h3;
        @(posedge mclk);
        {awaddr, wdata, awv, wv, bready} <= {a, d, 3'h7};
        while (pa || pw) begin
            @(negedge mclk);
            {ta, tw} = {awrdy && pa, wrdy && pw};
            @(posedge mclk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
            {pa, pw} = {pa && !ta, pw && !tw};
        end
        do @(negedge mclk); while (!bvalid);
        @(posedge mclk);
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        expq.push_back(e);
        @(posedge mclk);
        {araddr, arv, rready} <= {a, 2'h3};
        do @(negedge mclk); while (!arrdy);
        @(posedge mclk);
        arv <= 1'b0;
        do @(negedge mclk); while (!rvalid);
        @(posedge mclk);
        rready <= 1'b0;
    endtask : rd
    // k selects the port looked at: 1 read data, 2 pc, 3 flags
    task automatic xrd(input logic [3:0] id, input crs_size_t sz, input logic [1:0] k,
                       input logic [33:0] e);
        expq.push_back(e);
        i_crs_exec.sel(id, sz);
        xchk <= k;
        @(posedge mclk);
        xchk <= 2'h0;
    endtask : xrd
    task automatic results();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results
    initial begin
        repeat (3000) @(posedge mclk);
        errors++;
        results();
    end
    initial begin
        {rst_b, awv, wv, bready, arv, rready, awaddr, araddr, wdata, xchk} = '0;
        v = $urandom(32'ha4b1ebe1);
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        i_crs_exec.op(1'b1, ID_R0, SZ_WORD, 32'h0, 6'h10, 3'h0);
        rd(OFS_FLG, 34'h004);
        i_crs_exec.op(1'b1, ID_R0, SZ_BHI, 32'h5a, 6'h00, 3'h0);
        i_crs_exec.op(1'b1, ID_R0, SZ_BLO, 32'ha5, 6'h00, 3'h0);
        rd(8'h00, 34'h5aa5);
        i_crs_exec.op(1'b1, ID_R0, SZ_LONG, 32'h87654321, 6'h3d, 3'h0);
        i_crs_exec.op(1'b0, ID_NONE, SZ_WORD, 32'h1, 6'h22, 3'h0);
        xrd(ID_NONE, SZ_WORD, 2'h3, 34'h029);
        rd(OFS_FLG, 34'h029);
        rd(8'h08, 34'h8765);
        xrd(ID_R0, SZ_LONG, 2'h1, 34'h87654321);
        xrd(ID_R0, SZ_BHI, 2'h1, 34'h43);
        i_crs_exec.op(1'b1, ID_A0, SZ_LONG, 32'h1234abcd, 6'h00, 3'h0);
        rd(8'h14, 34'h1234);
        v = $urandom & 32'hfffff;
        wr(OFS_PC, v, RESP_OKAY);
        i_crs_exec.op(1'b0, ID_NONE, SZ_WORD, 32'h0, 6'h00, 3'h5);
        rd(OFS_PC, {2'h0, (v + 32'h5) & 32'hfffff});
        xrd(ID_NONE, SZ_WORD, 2'h2, {2'h0, (v + 32'h5) & 32'hfffff});
        v = $urandom;
        wr(OFS_SB, v, RESP_OKAY);
        rd(OFS_SB, {18'h0, v[15:0]});
        wr(OFS_VECTOR_TABLE_BASE, 32'hffffffff, RESP_OKAY);
        rd(OFS_VECTOR_TABLE_BASE, 34'hfffff);
        wr(OFS_FLG, 32'hfffff790, RESP_OKAY);
        rd(OFS_FLG, 34'h790);
        i_crs_exec.op(1'b1, ID_R1, SZ_LONG, 32'hcafe1234, 6'h00, 3'h0);
        xrd(ID_R1, SZ_LONG, 2'h1, 34'hcafe1234);
        i_crs_exec.op(1'b1, ID_SP, SZ_WORD, 32'h7777, 6'h00, 3'h0);
        i_crs_exec.op(1'b1, ID_R0, SZ_WORD, 32'hbeef, 6'h00, 3'h0);
        rd(OFS_BANK1, 34'hbeef);
        rd(OFS_USP, 34'h7777);
        rd(OFS_ISP, 34'h0);
        rd(8'h1c, {RESP_SLV, 32'h0});
        results();
    end
endmodule : cpu_register_set_test

//--- crs_core.sv
// Function
// RULE_01: four 16-bit data registers written and read by the execution unit.
// RULE_02: first two data registers take byte writes without touching the other byte.
// RULE_03: data regs pair to 32 bits, third over first, fourth over second.
// RULE_04: two 16-bit address registers, readable and writable like data registers.
// RULE_05: address registers pair to 32 bits, second one as upper half.
// RULE_06: 16-bit frame base register held for relative addressing.
// RULE_07: 20-bit vector table base register.
// RULE_08: 20-bit next instruction pointer, loaded or stepped each instruction.
// RULE_09: user and interrupt stack pointers, stack-select flag picks the active one.
// RULE_10: 16-bit static base register.
// RULE_11: flag register is 11 bits wide.
// RULE_12: carry flag captures alu carry, borrow or shift-out and holds it.
// RULE_13: software keeps debug flag at zero; hardware only stores it.
// RULE_14: zero flag set on zero result, cleared otherwise.
// RULE_15: sign flag set on negative result, cleared otherwise.
// RULE_16: bank-select flag picks register bank 0 or 1.
// RULE_17: overflow flag set on overflow, cleared otherwise.
// RULE_18: inactive stack pointer keeps its value.
// RULE_19: untouched flags hold; flag updates land with the result write.
//
// Implementation choices: register access over AXI4-Lite and the register offsets.
module crs_core (
    input  wire logic                MCLK,
    input  wire logic                RST_B,
    input  wire crs_pkg::crs_wr_t    EXEC_WR,
    input  wire crs_pkg::crs_alu_t   EXEC_ALU,
    input  wire logic [2:0]          EXEC_PC_STEP,
    input  wire crs_pkg::crs_rd_t    EXEC_RD,
    output logic [31:0]              EXEC_RD_DATA,
    output logic [19:0]              NIP,
    output logic [10:0]              FLAGS,
    input  wire logic [7:0]          S_AXI_AWADDR,
    input  wire logic                S_AXI_AWVALID,
    output logic                     S_AXI_AWREADY,
    input  wire logic [31:0]         S_AXI_WDATA,
    input  wire logic [3:0]          S_AXI_WSTRB,
    input  wire logic                S_AXI_WVALID,
    output logic                     S_AXI_WREADY,
    output logic [1:0]               S_AXI_BRESP,
    output logic                     S_AXI_BVALID,
    input  wire logic                S_AXI_BREADY,
    input  wire logic [7:0]          S_AXI_ARADDR,
    input  wire logic                S_AXI_ARVALID,
    output logic                     S_AXI_ARREADY,
    output logic [31:0]              S_AXI_RDATA,
    output logic [1:0]               S_AXI_RRESP,
    output logic                     S_AXI_RVALID,
    input  wire logic                S_AXI_RREADY
);
    import crs_pkg::*;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [15:0] bank_q [2][N_BANKED];
    logic [15:0] sb_q;
    logic [19:0] vector_table_base_q;
    logic [19:0] pc_q;
    logic [15:0] usp_q;
    logic [15:0] isp_q;
    logic [10:0] flg_q;
    logic        cur_bank;
    logic        exec_busy;
    logic        bus_commit;

    assign cur_bank  = flg_q[FLG_B];                                 // RULE_16
    assign exec_busy = EXEC_WR.we | EXEC_ALU.upd_c | EXEC_ALU.upd_z
                     | EXEC_ALU.upd_s | EXEC_ALU.upd_o | (|EXEC_PC_STEP);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] pair_hi(input logic [3:0] id);
        case (id)
            ID_R0:   pair_hi = ID_R2;                                // RULE_03
            ID_R1:   pair_hi = ID_R3;                                // RULE_03
            ID_A0:   pair_hi = ID_A1;                                // RULE_05
            default: pair_hi = ID_NONE;
        endcase
    endfunction : pair_hi

    function automatic crs_sel_t bus_decode(input logic [7:0] a);
        crs_sel_t s;
        s = '{ok: 1'b1, bank: 1'b0, id: ID_NONE};
        if ((a & BANK_MASK) == OFS_BANK0 || (a & BANK_MASK) == OFS_BANK1) begin
            s.bank = (a & BANK_MASK) == OFS_BANK1;
            s.id   = {2'h0, a[3:2]} | {1'b0, a[4], 2'h0};
            s.ok   = (a[1:0] == 2'h0) && (a[4:2] != 3'h7);
        end else begin
            case (a)
                OFS_SB:   s.id = ID_SB;
                OFS_VECTOR_TABLE_BASE: s.id = ID_VECTOR_TABLE_BASE;
                OFS_PC:   s.id = ID_PC;
                OFS_USP:  s.id = ID_USP;
                OFS_ISP:  s.id = ID_ISP;
                OFS_FLG:  s.id = ID_FLG;
                default:  s.ok = 1'b0;
            endcase
        end
        return s;
    endfunction : bus_decode

    function automatic logic [19:0] reg_val(input logic b, input logic [3:0] id);
        case (id)
            ID_R0, ID_R1, ID_R2, ID_R3,
            ID_A0, ID_A1, ID_FB: reg_val = {4'h0, bank_q[b][id[2:0]]};
            ID_SB:   reg_val = {4'h0, sb_q};
            ID_VECTOR_TABLE_BASE: reg_val = vector_table_base_q;
            ID_PC:   reg_val = pc_q;
            ID_USP:  reg_val = {4'h0, usp_q};
            ID_ISP:  reg_val = {4'h0, isp_q};
            ID_SP:   reg_val = {4'h0, flg_q[FLG_U] ? usp_q : isp_q}; // RULE_09
            ID_FLG:  reg_val = {9'h000, flg_q};
            default: reg_val = 20'h00000;
        endcase
    endfunction : reg_val

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] nv,
                                            input logic [1:0]  be);
        merge16 = {be[1] ? nv[15:8] : old[15:8], be[0] ? nv[7:0] : old[7:0]};
    endfunction : merge16

    // ------------------------------------------------------------
    // axi write channel
    // ------------------------------------------------------------
    logic        aw_held_q;
    logic        w_held_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    crs_sel_t    wsel;

    assign S_AXI_AWREADY = ~aw_held_q;
    assign S_AXI_WREADY  = ~w_held_q;
    assign S_AXI_BVALID  = bvalid_q;
    assign S_AXI_BRESP   = bresp_q;
    assign wsel          = bus_decode(awaddr_q);
    // bus waits while the execution unit writes back
    assign bus_commit    = aw_held_q & w_held_q & ~bvalid_q & ~exec_busy;

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awaddr_q  <= 8'h00;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && !aw_held_q) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && !w_held_q) begin
                w_held_q <= 1'b1;
                wdata_q  <= S_AXI_WDATA;
                wstrb_q  <= S_AXI_WSTRB;
            end
            if (bus_commit) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wsel.ok ? RESP_OKAY : RESP_SLV;
            end else if (bvalid_q && S_AXI_BREADY) begin
                bvalid_q  <= 1'b0;
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // axi read channel
    // ------------------------------------------------------------
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    crs_sel_t    rsel;

    assign S_AXI_ARREADY = ~rvalid_q;
    assign S_AXI_RVALID  = rvalid_q;
    assign S_AXI_RDATA   = rdata_q;
    assign S_AXI_RRESP   = rresp_q;
    assign rsel          = bus_decode(S_AXI_ARADDR);

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= RESP_OKAY;
        end else if (S_AXI_ARVALID && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rsel.ok ? {12'h000, reg_val(rsel.bank, rsel.id)} : 32'h0000_0000;
            rresp_q  <= rsel.ok ? RESP_OKAY : RESP_SLV;
        end else if (rvalid_q && S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // banked data, address and frame base registers
    // ------------------------------------------------------------
    for (genvar b = 0; b < 2; b++) begin : g_bank
        for (genvar k = 0; k < N_BANKED; k++) begin : g_reg
            logic [1:0]  be;
            logic [15:0] nd;
            always_comb begin
                be = 2'h0;
                nd = EXEC_WR.data[15:0];
                if (bus_commit && wsel.ok && wsel.bank == 1'(b) && wsel.id == 4'(k)) begin
                    be = wstrb_q[1:0];
                    nd = wdata_q[15:0];
                end else if (EXEC_WR.we && cur_bank == 1'(b)) begin       // RULE_16
                    if (EXEC_WR.id == 4'(k)) begin
                        case (EXEC_WR.size)
                            SZ_BLO:  be = (k < 2) ? 2'h1 : 2'h0;        // RULE_02
                            SZ_BHI: begin
                                be = (k < 2) ? 2'h2 : 2'h0;              // RULE_02
                                nd = {EXEC_WR.data[7:0], 8'h00};
                            end
                            SZ_WORD: be = 2'h3;                          // RULE_01 RULE_04 RULE_06
                            SZ_LONG: be = (pair_hi(4'(k)) != ID_NONE) ? 2'h3 : 2'h0;
                            default: be = 2'h0;
                        endcase
                    end else if (EXEC_WR.size == SZ_LONG && pair_hi(EXEC_WR.id) == 4'(k)) begin
                        be = 2'h3;                                       // RULE_03 RULE_05
                        nd = EXEC_WR.data[31:16];
                    end
                end
            end
            always_ff @(posedge MCLK) begin
                if (!RST_B) begin
                    bank_q[b][k] <= RST_REG16;
                end else if (|be) begin
                    bank_q[b][k] <= merge16(bank_q[b][k], nd, be);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // unbanked registers
    // ------------------------------------------------------------
    function automatic logic bus_hit(input logic [3:0] id);
        bus_hit = bus_commit && wsel.ok && wsel.id == id;
    endfunction : bus_hit

    function automatic logic ex_hit(input logic [3:0] id);
        ex_hit = EXEC_WR.we && EXEC_WR.size != SZ_LONG && EXEC_WR.id == id;
    endfunction : ex_hit

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            sb_q   <= RST_REG16;
            vector_table_base_q <= RST_REG20;
        end else begin
            if (bus_hit(ID_SB))
                sb_q <= merge16(sb_q, wdata_q[15:0], wstrb_q[1:0]);
            else if (ex_hit(ID_SB))
                sb_q <= EXEC_WR.data[15:0];                             // RULE_10
            if (bus_hit(ID_VECTOR_TABLE_BASE))
                vector_table_base_q <= {wstrb_q[2] ? wdata_q[19:16] : vector_table_base_q[19:16],
                           merge16(vector_table_base_q[15:0], wdata_q[15:0], wstrb_q[1:0])};
            else if (ex_hit(ID_VECTOR_TABLE_BASE))
                vector_table_base_q <= EXEC_WR.data[19:0];                           // RULE_07
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            pc_q <= RST_REG20;
        end else if (bus_hit(ID_PC)) begin
            pc_q <= {wstrb_q[2] ? wdata_q[19:16] : pc_q[19:16],
                     merge16(pc_q[15:0], wdata_q[15:0], wstrb_q[1:0])};
        end else if (ex_hit(ID_PC)) begin
            pc_q <= EXEC_WR.data[19:0];                                 // RULE_08
        end else if (|EXEC_PC_STEP) begin
            pc_q <= pc_q + {17'h00000, EXEC_PC_STEP};                   // RULE_08
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            usp_q <= RST_REG16;
            isp_q <= RST_REG16;
        end else begin
            if (bus_hit(ID_USP))
                usp_q <= merge16(usp_q, wdata_q[15:0], wstrb_q[1:0]);
            else if (ex_hit(ID_USP) || (ex_hit(ID_SP) && flg_q[FLG_U]))   // RULE_09 RULE_18
                usp_q <= EXEC_WR.data[15:0];
            if (bus_hit(ID_ISP))
                isp_q <= merge16(isp_q, wdata_q[15:0], wstrb_q[1:0]);
            else if (ex_hit(ID_ISP) || (ex_hit(ID_SP) && !flg_q[FLG_U]))  // RULE_09 RULE_18
                isp_q <= EXEC_WR.data[15:0];
        end
    end

    // ------------------------------------------------------------
    // flags
    // ------------------------------------------------------------
    logic res_zero;
    logic res_neg;

    always_comb begin
        case (EXEC_WR.size)
            SZ_WORD: begin
                res_zero = EXEC_WR.data[15:0] == 16'h0000;
                res_neg  = EXEC_WR.data[15];
            end
            SZ_LONG: begin
                res_zero = EXEC_WR.data == 32'h0000_0000;
                res_neg  = EXEC_WR.data[31];
            end
            default: begin
                res_zero = EXEC_WR.data[7:0] == 8'h00;
                res_neg  = EXEC_WR.data[7];
            end
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            flg_q <= RST_FLG;                                           // RULE_11
        end else if (bus_hit(ID_FLG)) begin
            flg_q <= {wstrb_q[1] ? wdata_q[10:FLG_LANE] : flg_q[10:FLG_LANE],
                      wstrb_q[0] ? wdata_q[FLG_LANE-1:0] : flg_q[FLG_LANE-1:0]};
        end else if (ex_hit(ID_FLG)) begin
            flg_q <= EXEC_WR.data[10:0];
        end else begin
            // bits without an update strobe hold
            if (EXEC_ALU.upd_c)
                flg_q[FLG_C] <= EXEC_ALU.carry;                         // RULE_12 RULE_19
            if (EXEC_ALU.upd_z)
                flg_q[FLG_Z] <= res_zero;                               // RULE_14 RULE_19
            if (EXEC_ALU.upd_s)
                flg_q[FLG_S] <= res_neg;                                // RULE_15 RULE_19
            if (EXEC_ALU.upd_o)
                flg_q[FLG_O] <= EXEC_ALU.ovf;                           // RULE_17 RULE_19
        end
    end

    // ------------------------------------------------------------
    // execution read port and status outputs
    // ------------------------------------------------------------
    logic [19:0] rd_lo;
    logic [19:0] rd_hi;

    assign rd_lo = reg_val(cur_bank, EXEC_RD.id);
    assign rd_hi = reg_val(cur_bank, pair_hi(EXEC_RD.id));

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            EXEC_RD_DATA <= 32'h0000_0000;
        end else if (EXEC_RD.size == SZ_LONG) begin
            EXEC_RD_DATA <= {rd_hi[15:0], rd_lo[15:0]};                 // RULE_03 RULE_05
        end else if (EXEC_RD.size == SZ_BHI) begin
            EXEC_RD_DATA <= {24'h000000, rd_lo[15:8]};                  // RULE_02
        end else if (EXEC_RD.size == SZ_BLO) begin
            EXEC_RD_DATA <= {24'h000000, rd_lo[7:0]};
        end else begin
            EXEC_RD_DATA <= {12'h000, rd_lo};
        end
    end

    assign NIP   = pc_q;
    assign FLAGS = flg_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);

    logic ex_flg_wr;
    assign ex_flg_wr = ex_hit(ID_FLG);

    a_carry_capture: assert property (EXEC_ALU.upd_c && !ex_flg_wr |=> flg_q[FLG_C] == $past(EXEC_ALU.carry)) else $error("carry not captured"); // RULE_12
    a_zero_word: assert property (EXEC_ALU.upd_z && !ex_flg_wr && EXEC_WR.size == SZ_WORD
        |=> flg_q[FLG_Z] == ($past(EXEC_WR.data[15:0]) == 16'h0000)) else $error("zero flag wrong"); // RULE_14
    a_sign_long: assert property (EXEC_ALU.upd_s && !ex_flg_wr && EXEC_WR.size == SZ_LONG
        |=> flg_q[FLG_S] == $past(EXEC_WR.data[31])) else $error("sign flag wrong"); // RULE_15
    a_ovf_capture: assert property (EXEC_ALU.upd_o && !ex_flg_wr |=> flg_q[FLG_O] == $past(EXEC_ALU.ovf)) else $error("overflow not captured"); // RULE_17
    a_flag_hold: assert property (exec_busy && !EXEC_ALU.upd_c && !ex_flg_wr |=> $stable(flg_q[FLG_C])) else $error("carry moved without update"); // RULE_19
    a_byte_keep: assert property (EXEC_WR.we && EXEC_WR.id == ID_R0 && EXEC_WR.size == SZ_BLO && !cur_bank
        |=> bank_q[0][0][15:8] == $past(bank_q[0][0][15:8]) && bank_q[0][0][7:0] == $past(EXEC_WR.data[7:0])) else $error("byte write disturbed"); // RULE_02
    a_long_pair: assert property (EXEC_WR.we && EXEC_WR.id == ID_R1 && EXEC_WR.size == SZ_LONG && cur_bank
        |=> bank_q[1][3] == $past(EXEC_WR.data[31:16]) && bank_q[1][1] == $past(EXEC_WR.data[15:0])) else $error("long pair wrong"); // RULE_03
    a_addr_pair: assert property (EXEC_WR.we && EXEC_WR.id == ID_A0 && EXEC_WR.size == SZ_LONG && !cur_bank
        |=> bank_q[0][5] == $past(EXEC_WR.data[31:16])) else $error("address pair wrong"); // RULE_05
    a_bank_other: assert property (EXEC_WR.we && cur_bank |=> $stable(bank_q[0][0])) else $error("inactive bank written"); // RULE_16
    a_sp_inactive: assert property (ex_hit(ID_SP) && flg_q[FLG_U] |=> $stable(isp_q) ##1 $stable(isp_q) or !(!exec_busy && !bus_commit)) else $error("inactive stack pointer moved"); // RULE_18
    a_pc_step: assert property (|EXEC_PC_STEP && !EXEC_WR.we && !bus_commit
        |=> pc_q == $past(pc_q) + {17'h00000, $past(EXEC_PC_STEP)}) else $error("pc step wrong"); // RULE_08
    a_bus_resp: assert property (bus_commit |=> S_AXI_BVALID) else $error("write response missing");
    a_read_resp: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID) else $error("read response missing");

    c_long_write: cover property (EXEC_WR.we && EXEC_WR.size == SZ_LONG);
    c_byte_hi: cover property (EXEC_WR.we && EXEC_WR.size == SZ_BHI && EXEC_WR.id == ID_R1);
    c_sp_switch: cover property (flg_q[FLG_U] ##1 !flg_q[FLG_U]);
    c_bus_write: cover property (bus_commit && wsel.ok);

endmodule : crs_core

//--- crs_exec.sv
module crs_exec (
    input  wire logic         MCLK,
    output crs_pkg::crs_wr_t  EXEC_WR,
    output crs_pkg::crs_alu_t EXEC_ALU,
    output logic [2:0]        EXEC_PC_STEP,
    output crs_pkg::crs_rd_t  EXEC_RD
);
    timeunit 1ns;
    timeprecision 1ns;
    import crs_pkg::*;
    initial {EXEC_WR, EXEC_ALU, EXEC_PC_STEP, EXEC_RD} = '0;
    // one operation held for one cycle, then idle
    task automatic op(input logic we, input logic [3:0] id, input crs_size_t sz,
                      input logic [31:0] d, input crs_alu_t a, input logic [2:0] st);
        @(posedge MCLK);
        {EXEC_WR, EXEC_ALU, EXEC_PC_STEP} <= {we, id, sz, d, a, st};
        @(posedge MCLK);
        {EXEC_WR, EXEC_ALU, EXEC_PC_STEP} <= '0;
    endtask : op
    // select a register on the read port; data stands one edge later
    task automatic sel(input logic [3:0] id, input crs_size_t sz);
        @(posedge MCLK);
        EXEC_RD <= {id, sz};
        @(posedge MCLK);
    endtask : sel
endmodule : crs_exec

//--- crs_pkg.sv
package crs_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int DATA_W   = 16;
    localparam int WIDE_W   = 20;
    localparam int FLAG_W   = 11;
    localparam int N_BANKED = 7;
    localparam int AXI_AW   = 8;

    // ------------------------------------------------------------
    // register identifiers
    // ------------------------------------------------------------
    localparam logic [3:0] ID_R0   = 4'h0;
    localparam logic [3:0] ID_R1   = 4'h1;
    localparam logic [3:0] ID_R2   = 4'h2;
    localparam logic [3:0] ID_R3   = 4'h3;
    localparam logic [3:0] ID_A0   = 4'h4;
    localparam logic [3:0] ID_A1   = 4'h5;
    localparam logic [3:0] ID_FB   = 4'h6;
    localparam logic [3:0] ID_SB   = 4'h7;
    localparam logic [3:0] ID_VECTOR_TABLE_BASE = 4'h8;
    localparam logic [3:0] ID_PC   = 4'h9;
    localparam logic [3:0] ID_USP  = 4'ha;
    localparam logic [3:0] ID_ISP  = 4'hb;
    localparam logic [3:0] ID_SP   = 4'hc;
    localparam logic [3:0] ID_FLG  = 4'hd;
    localparam logic [3:0] ID_NONE = 4'hf;

    // ------------------------------------------------------------
    // flag bit positions
    // ------------------------------------------------------------
    localparam int FLG_C    = 0;
    localparam int FLG_D    = 1;
    localparam int FLG_Z    = 2;
    localparam int FLG_S    = 3;
    localparam int FLG_B    = 4;
    localparam int FLG_O    = 5;
    localparam int FLG_I    = 6;
    localparam int FLG_U    = 7;
    localparam int FLG_LANE = 8;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_REG16 = 16'h0000;
    localparam logic [19:0] RST_REG20 = 20'h00000;
    localparam logic [10:0] RST_FLG   = 11'h000;

    // ------------------------------------------------------------
    // bus map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_BANK0 = 8'h00;
    localparam logic [7:0] OFS_BANK1 = 8'h20;
    localparam logic [7:0] OFS_SB    = 8'h40;
    localparam logic [7:0] OFS_VECTOR_TABLE_BASE  = 8'h44;
    localparam logic [7:0] OFS_PC    = 8'h48;
    localparam logic [7:0] OFS_USP   = 8'h4c;
    localparam logic [7:0] OFS_ISP   = 8'h50;
    localparam logic [7:0] OFS_FLG   = 8'h54;
    localparam logic [7:0] BANK_MASK = 8'he0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLV  = 2'h2;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SZ_BLO  = 2'h0,
        SZ_BHI  = 2'h1,
        SZ_WORD = 2'h2,
        SZ_LONG = 2'h3
    } crs_size_t;

    typedef struct packed {
        logic        we;
        logic [3:0]  id;
        crs_size_t   size;
        logic [31:0] data;
    } crs_wr_t;

    typedef struct packed {
        logic upd_c;
        logic upd_z;
        logic upd_s;
        logic upd_o;
        logic carry;
        logic ovf;
    } crs_alu_t;

    typedef struct packed {
        logic [3:0] id;
        crs_size_t  size;
    } crs_rd_t;

    typedef struct packed {
        logic       ok;
        logic       bank;
        logic [3:0] id;
    } crs_sel_t;

endpackage : crs_pkg
